/* core/adc_input_select_clock.v */
// Converter control: references, conversion clock, pin config, input mux.
// Assumes a single 20 MHz system clock as instruction clock, a simple
// register port, and an RC clock request that the analog side honours.
// Notes on behaviour
// - Reference select field CON2[15:13] picks rails or external pins.
// - A conversion lasts 12 periods in 10-bit mode, 14 in 12-bit.
// - Instruction clock source: period is cycle times divide field plus one.
// - RC source bit CON3[15] selects RC clock; divide field then ignored.
// - Pin config bit clear means analog; both registers reset to zero.
// - Analog pins disable digital input; port reads return zero.
// - Set config bit makes pin digital; its positive mux inputs go to ground, negative ones do not.
// - Directions reset to input; driven analog pin samples its output level.
// - Set A positive field CH0[4:0] picks channel 0 positive input.
// - Set A negative bit CH0[7] picks reference or AN1 for channel 0.
// - Alternation off uses set A; on alternates A then B per sequence.
// - Set B fields CH0[12:8] and CH0[15] mirror set A meaning.
// - Simultaneous or 12-bit: alternate every sample; sequential 10-bit: after every channel's sample.
// - Scan enable CON2[10] steps channel 0 through scan list.
// - Scan bit n includes input n; ascending, restarting after interrupt.
// - Inputs beyond the samples per interrupt are not reached.
// - Scanning changes only the positive input; set A negative still used.
// - Scan with alternation: scanned input alternates with fixed set B.
// - Channels 1-3 positive bit picks AN0-AN2 or AN3-AN5.
// - Channels 1-3 negative field: reference, AN6-AN8 or AN9-AN11.
// - CON1[10] selects 10-bit or 12-bit mode.
`include "adc_sel_defines.vh"
module adc_input_select_clock #(
    parameter NPINS = 32
) (
    CLK_SYS,
    SRST,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    SAMPLE_PULSE,
    SEQ_END,
    IRQ_PULSE,
    PIN_IN,
    PIN_OUT,
    REF_SEL,
    RC_CLK_SEL,
    TAD_TICK,
    CONV_BUSY,
    CONV_DONE,
    CH0_POS,
    CH0_NEG,
    CH1_POS,
    CH2_POS,
    CH3_POS,
    CH123_NEG,
    PIN_ANALOG,
    DIR_INPUT
);
    input  wire              CLK_SYS;
    input  wire              SRST;
    input  wire [3:0]        ADDR;
    input  wire [15:0]       WDATA;
    input  wire              WR;
    input  wire              RD;
    output reg  [15:0]       RDATA;
    input  wire              SAMPLE_PULSE;
    input  wire              SEQ_END;
    input  wire              IRQ_PULSE;
    input  wire [NPINS-1:0]  PIN_IN;
    output reg  [NPINS-1:0]  PIN_OUT;
    output reg  [2:0]        REF_SEL;
    output reg               RC_CLK_SEL;
    output reg               TAD_TICK;
    output reg               CONV_BUSY;
    output reg               CONV_DONE;
    output reg  [4:0]        CH0_POS;
    output reg  [4:0]        CH0_NEG;
    output reg  [4:0]        CH1_POS;
    output reg  [4:0]        CH2_POS;
    output reg  [4:0]        CH3_POS;
    output reg  [4:0]        CH123_NEG;
    output reg  [NPINS-1:0]  PIN_ANALOG;
    output reg  [NPINS-1:0]  DIR_INPUT;

    reg [15:0]      con1;
    reg [15:0]      con2;
    reg [15:0]      con3;
    reg [15:0]      ch123_sel;
    reg [15:0]      ch0_sel;
    reg [31:0]      scan_sel;
    reg [31:0]      pin_cfg;
    reg [31:0]      port_out;
    reg [NPINS-1:0] pin_meta;
    reg [NPINS-1:0] pin_sync;
    reg [NPINS-1:0] port_read;
    reg             use_b;
    reg [3:0]       seq_chan;
    reg [4:0]       scan_pos;
    reg             scan_valid;
    reg [7:0]       tad_cnt;
    reg [7:0]       bit_cnt;
    reg             start_req;
    reg [4:0]       next_scan;
    reg             next_found;
    reg [4:0]       first_scan;
    reg             first_found;
    reg [4:0]       pos0;
    reg [4:0]       neg0;
    reg [4:0]       pos123;
    reg [1:0]       neg123;
    reg [4:0]       base;
    reg [4:0]       p0;
    reg [4:0]       p1;
    reg [4:0]       p2;
    reg [4:0]       p3;
    reg [4:0]       n123;
    wire [NPINS-1:0] digital;
    wire            alt_en;
    wire            sim;
    wire [1:0]      channels_per_sample;
    wire [7:0]      div;
    wire [7:0]      tad_bits;
    integer         i;
    genvar          g;

    assign digital  = pin_cfg[NPINS-1:0];
    assign alt_en   = con2[`CON2_ALT_BIT];
    assign sim      = con1[`CON1_SIMULTANEOUS_SAMPLE_SEL_BIT];
    assign channels_per_sample     = con2[`CON2_CHANNELS_PER_SAMPLE_HI:`CON2_CHANNELS_PER_SAMPLE_LO];
    assign div      = con3[`CON3_DIV_HI:`CON3_DIV_LO];
    assign tad_bits = con1[`CON1_RES_BIT] ? `TAD_BITS_12
                                          : `TAD_BITS_10;

    // Analog pins read zero; digital pins see the synchronised pin level.
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_port
            always @* begin
                port_read[g] = digital[g] & pin_sync[g];
            end
        end
    endgenerate

    // Next and first selected scan inputs, ascending.
    always @* begin
        next_scan   = 5'h00;
        next_found  = 1'b0;
        first_scan  = 5'h00;
        first_found = 1'b0;
        for (i = 31; i >= 0; i = i - 1) begin
            if (scan_sel[i]) begin
                first_scan  = i[4:0];
                first_found = 1'b1;
                if (i[4:0] > scan_pos) begin
                    next_scan  = i[4:0];
                    next_found = 1'b1;
                end
            end
        end
    end

    // Input mux: set selection, scanning and ground on digital pins.
    always @* begin
        if (use_b) begin
            pos0   = ch0_sel[`CH0_POS_B_HI:`CH0_POS_B_LO];
            neg0   = ch0_sel[`CH0_NEG_B_BIT] ? 5'h01 : `NEG_SEL_VREF;
            pos123 = {4'h0, ch123_sel[`CH123_POS_B_BIT]};
            neg123 = ch123_sel[`CH123_NEG_B_HI:`CH123_NEG_B_LO];
        end else begin
            pos0   = con2[`CON2_SCAN_BIT] ? scan_pos
                     : ch0_sel[`CH0_POS_A_HI:`CH0_POS_A_LO];
            neg0   = ch0_sel[`CH0_NEG_A_BIT] ? 5'h01
                     : `NEG_SEL_VREF;
            pos123 = {4'h0, ch123_sel[`CH123_POS_A_BIT]};
            neg123 = ch123_sel[`CH123_NEG_A_HI:`CH123_NEG_A_LO];
        end
        base = pos123[0] ? 5'h03 : 5'h00;
        p0 = digital[pos0[4:0] % NPINS] ? `INPUT_GROUND : pos0;
        p1 = digital[base] ? `INPUT_GROUND : base;
        p2 = digital[base + 5'h01] ? `INPUT_GROUND : base + 5'h01;
        p3 = digital[base + 5'h02] ? `INPUT_GROUND : base + 5'h02;
        if (!neg123[1]) begin
            n123 = `NEG_SEL_VREF;
        end else begin
            n123 = neg123[0] ? 5'h09 : 5'h06;
        end
    end

    // Register port and configuration state.
    always @(posedge CLK_SYS) begin
        pin_meta <= PIN_IN;
        pin_sync <= pin_meta;
        if (SRST) begin
            con1      <= 16'h0000;
            con2      <= 16'h0000;
            con3      <= 16'h0000;
            ch123_sel <= 16'h0000;
            ch0_sel   <= 16'h0000;
            scan_sel  <= 32'h00000000;
            pin_cfg   <= 32'h00000000;
            port_out  <= 32'hFFFFFFFF;
            RDATA     <= 16'h0000;
            start_req <= 1'b0;
        end else begin
            start_req <= WR && ADDR == `REG_SEQ_CTRL && WDATA[0];
            if (WR) begin
                case (ADDR)
                    `REG_CON1:      con1 <= WDATA;
                    `REG_CON2:      con2 <= WDATA;
                    `REG_CON3:      con3 <= WDATA;
                    `REG_CH123_SEL: ch123_sel <= WDATA;
                    `REG_CH0_SEL:   ch0_sel <= WDATA;
                    `REG_SCAN_HIGH: scan_sel[31:16] <= WDATA;
                    `REG_SCAN_LOW:  scan_sel[15:0] <= WDATA;
                    `REG_PIN_DIGITAL_CFG_HIGH: pin_cfg[31:16] <= WDATA;
                    `REG_PIN_DIGITAL_CFG_LOW:  pin_cfg[15:0] <= WDATA;
                    `REG_DIRECTION: port_out[15:0] <= WDATA;
                    default:        con1 <= con1;
                endcase
            end
            RDATA <= 16'h0000;
            if (RD) begin
                case (ADDR)
                    `REG_CON1:      RDATA <= con1;
                    `REG_CON2:      RDATA <= con2;
                    `REG_CON3:      RDATA <= con3;
                    `REG_CH123_SEL: RDATA <= ch123_sel;
                    `REG_CH0_SEL:   RDATA <= ch0_sel;
                    `REG_SCAN_HIGH: RDATA <= scan_sel[31:16];
                    `REG_SCAN_LOW:  RDATA <= scan_sel[15:0];
                    `REG_PIN_DIGITAL_CFG_HIGH: RDATA <= pin_cfg[31:16];
                    `REG_PIN_DIGITAL_CFG_LOW:  RDATA <= pin_cfg[15:0];
                    `REG_DIRECTION: RDATA <= port_out[15:0];
                    `REG_PORT:      RDATA <= port_read[15:0];
                    `REG_STATUS:    RDATA <= {11'h000, scan_pos};
                    default:        RDATA <= {14'h0, use_b, CONV_BUSY};
                endcase
            end
        end
    end

    // Alternation and scan sequencing.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            use_b      <= 1'b0;
            seq_chan   <= 4'h0;
            scan_pos   <= 5'h00;
            scan_valid <= 1'b0;
        end else begin
            if (!alt_en) begin
                use_b <= 1'b0;
            end else if (SAMPLE_PULSE) begin
                // Sequential 10-bit sampling flips only after every channel's turn; 12-bit flips every sample.
                if (sim || channels_per_sample == 2'b00 || con1[`CON1_RES_BIT]) begin
                    use_b <= ~use_b;
                end else if (seq_chan == (channels_per_sample[1] ? 4'h3 : 4'h1)) begin
                    use_b <= ~use_b;
                end
            end
            if (SAMPLE_PULSE) begin
                if (sim || channels_per_sample == 2'b00) begin
                    seq_chan <= 4'h0;
                end else if (seq_chan == (channels_per_sample[1] ? 4'h3 : 4'h1)) begin
                    seq_chan <= 4'h0;
                end else begin
                    seq_chan <= seq_chan + 4'h1;
                end
            end
            if (IRQ_PULSE || !scan_valid) begin
                scan_pos   <= first_scan;
                scan_valid <= first_found;
            end else if (SEQ_END && (!alt_en || use_b)) begin
                scan_pos <= next_found ? next_scan : first_scan;
            end
        end
    end

    // Conversion clock and conversion length.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            tad_cnt    <= 8'h00;
            bit_cnt    <= 8'h00;
            TAD_TICK   <= 1'b0;
            CONV_BUSY  <= 1'b0;
            CONV_DONE  <= 1'b0;
            REF_SEL    <= 3'h0;
            RC_CLK_SEL <= 1'b0;
        end else begin
            REF_SEL    <= con2[`CON2_REF_HI:`CON2_REF_LO];
            RC_CLK_SEL <= con3[`CON3_RC_BIT];
            CONV_DONE  <= 1'b0;
            TAD_TICK   <= 1'b0;
            if (con3[`CON3_RC_BIT]) begin
                tad_cnt <= 8'h00;
            end else if (tad_cnt >= div) begin
                tad_cnt  <= 8'h00;
                TAD_TICK <= 1'b1;
            end else begin
                tad_cnt <= tad_cnt + 8'h01;
            end
            if (start_req && !CONV_BUSY) begin
                CONV_BUSY <= 1'b1;
                bit_cnt   <= 8'h00;
            end else if (CONV_BUSY && TAD_TICK) begin
                if (bit_cnt == tad_bits - 8'h01) begin
                    CONV_BUSY <= 1'b0;
                    CONV_DONE <= 1'b1;
                end else begin
                    bit_cnt <= bit_cnt + 8'h01;
                end
            end
        end
    end

    // Registered mux and pin outputs.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            CH0_POS    <= 5'h00;
            CH0_NEG    <= 5'h00;
            CH1_POS    <= 5'h00;
            CH2_POS    <= 5'h00;
            CH3_POS    <= 5'h00;
            CH123_NEG  <= 5'h00;
            PIN_ANALOG <= {NPINS{1'b1}};
            DIR_INPUT  <= {NPINS{1'b1}};
            PIN_OUT    <= {NPINS{1'b0}};
        end else begin
            CH0_POS    <= p0;
            CH0_NEG    <= neg0;
            CH1_POS    <= p1;
            CH2_POS    <= p2;
            CH3_POS    <= p3;
            CH123_NEG  <= n123;
            PIN_ANALOG <= ~digital;
            // A cleared direction bit drives the pin, even if analog.
            DIR_INPUT  <= port_out[NPINS-1:0];
            PIN_OUT    <= {NPINS{1'b0}};
        end
    end
endmodule

/* shared/adc_sel_defines.vh */
// Constants for the converter input select and clock control block.
// Assumes inclusion by bare name from design and bench files.
`ifndef ADC_SEL_DEFINES_VH
`define ADC_SEL_DEFINES_VH
`define REG_CON1          4'h0
`define REG_CON2          4'h1
`define REG_CON3          4'h2
`define REG_CH123_SEL     4'h3
`define REG_CH0_SEL       4'h4
`define REG_SCAN_HIGH     4'h5
`define REG_SCAN_LOW      4'h6
`define REG_PIN_DIGITAL_CFG_HIGH     4'h7
`define REG_PIN_DIGITAL_CFG_LOW      4'h8
`define REG_DIRECTION     4'h9
`define REG_PORT          4'hA
`define REG_SEQ_CTRL      4'hB
`define REG_STATUS        4'hC
`define CON1_RES_BIT      10
`define CON1_SIMULTANEOUS_SAMPLE_SEL_BIT   3
`define CON2_REF_HI       15
`define CON2_REF_LO       13
`define CON2_SCAN_BIT     10
`define CON2_CHANNELS_PER_SAMPLE_HI      9
`define CON2_CHANNELS_PER_SAMPLE_LO      8
`define CON2_ALT_BIT      0
`define CON3_RC_BIT       15
`define CON3_DIV_HI       7
`define CON3_DIV_LO       0
`define CH0_NEG_B_BIT     15
`define CH0_POS_B_HI      12
`define CH0_POS_B_LO      8
`define CH0_NEG_A_BIT     7
`define CH0_POS_A_HI      4
`define CH0_POS_A_LO      0
`define CH123_NEG_B_HI    10
`define CH123_NEG_B_LO    9
`define CH123_POS_B_BIT   8
`define CH123_NEG_A_HI    2
`define CH123_NEG_A_LO    1
`define CH123_POS_A_BIT   0
`define TAD_BITS_10       8'h0C
`define TAD_BITS_12       8'h0E
`define TAD_MIN_NS        75
`define CLK_PERIOD_NS     50
`define TAD_MIN_CYCLES    ((`TAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NEG_SEL_VREF      5'h1F
`define INPUT_GROUND      5'h1E
`endif

/* test/adc_sel_sva.sv */
// Checker for the converter control block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`include "adc_sel_defines.vh"
module adc_sel_sva #(
    parameter NPINS = 32
) (
    input wire logic             CLK_SYS,
    input wire logic             SRST,
    input wire logic [3:0]       ADDR,
    input wire logic [15:0]      WDATA,
    input wire logic             WR,
    input wire logic             RD,
    input wire logic [15:0]      RDATA,
    input wire logic [2:0]       REF_SEL,
    input wire logic             RC_CLK_SEL,
    input wire logic             TAD_TICK,
    input wire logic             CONV_BUSY,
    input wire logic             CONV_DONE,
    input wire logic [4:0]       CH1_POS,
    input wire logic [4:0]       CH2_POS,
    input wire logic [NPINS-1:0] PIN_ANALOG,
    input wire logic [NPINS-1:0] DIR_INPUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ref_sh;
    logic [7:0] div_sh;
    logic [9:0] since;
    logic [8:0] gap;
    logic [4:0] ticks;
    logic       rc_sh, res_sh, run;
    wire        wr_clk = WR && (ADDR == `REG_CON2 || ADDR == `REG_CON3);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    // Shadows of written fields; tick spacing only counts inside one run.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            ref_sh <= 3'h0;
            div_sh <= 8'h00;
            rc_sh  <= 1'b0;
            res_sh <= 1'b0;
            since  <= 10'h000;
            gap    <= 9'h000;
            run    <= 1'b0;
            ticks  <= 5'h00;
        end else begin
            if (WR && ADDR == `REG_CON1) res_sh <= WDATA[`CON1_RES_BIT];
            if (WR && ADDR == `REG_CON2) ref_sh <= WDATA[15:13];
            if (WR && ADDR == `REG_CON3) rc_sh <= WDATA[15];
            if (WR && ADDR == `REG_CON3) div_sh <= WDATA[7:0];
            if (wr_clk) since <= 10'h000;
            else if (since != 10'h3FF) since <= since + 10'h001;
            gap <= TAD_TICK ? 9'h001 : gap + {8'h00, gap != 9'h1FF};
            run <= CONV_BUSY && (run || TAD_TICK);
            ticks <= CONV_DONE ? 5'h00 : ticks + {4'h0, TAD_TICK && CONV_BUSY};
        end
    end

    a_ref_follow: assert property (since > 10'd2 |-> REF_SEL == ref_sh)
        else $error("reference select differs from written field");
    a_rc_follow: assert property (since > 10'd2 |-> RC_CLK_SEL == rc_sh)
        else $error("clock source differs from written bit");
    a_tick_gap: assert property (TAD_TICK && run && CONV_BUSY
        && !RC_CLK_SEL && since > 10'd600 |-> gap == {1'b0, div_sh} + 9'h001)
        else $error("conversion clock period wrong");
    a_rc_silent: assert property (RC_CLK_SEL [*3] |-> !TAD_TICK)
        else $error("divided tick while on internal clock");
    a_conv_count: assert property (CONV_DONE
        |-> ticks == (res_sh ? 5'd14 : 5'd12))
        else $error("conversion length wrong");
    a_port_zero: assert property ($past(RD) && $past(ADDR) == `REG_PORT
        |-> (RDATA & PIN_ANALOG[15:0]) == 16'h0000)
        else $error("analog pin read as one");
    a_ch123_step: assert property (!$past(SRST) && CH1_POS != 5'h1E
        && CH2_POS != 5'h1E |-> CH2_POS == CH1_POS + 5'h01)
        else $error("channel 2 input not next to channel 1");
    a_reset_ones: assert property ($fell(SRST)
        |-> &DIR_INPUT && &PIN_ANALOG)
        else $error("pins not analog inputs after reset");
    cover property (CONV_DONE && res_sh);
    cover property (TAD_TICK && run && since > 10'd600);
    cover property ($past(RD) && $past(ADDR) == `REG_PORT);
endmodule
bind adc_input_select_clock adc_sel_sva #(.NPINS(NPINS)) i_adc_sel_sva (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .REF_SEL(REF_SEL), .RC_CLK_SEL(RC_CLK_SEL),
    .TAD_TICK(TAD_TICK), .CONV_BUSY(CONV_BUSY), .CONV_DONE(CONV_DONE),
    .CH1_POS(CH1_POS), .CH2_POS(CH2_POS), .PIN_ANALOG(PIN_ANALOG),
    .DIR_INPUT(DIR_INPUT));

/* test/pin_model.sv */
// Model of the analog pin side: presents the levels set by the bench.
// Assumes pins are always driven, so no float or pull is modelled.
module pin_model #(
    parameter N = 32
) (
    input  wire logic [N-1:0] level,
    output logic      [N-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    assign pin = level;
endmodule

/* test/tb.sv */
// Self-checking bench for the converter control block.
// Assumes the defines header, pin model and checker are compiled first.
`include "adc_sel_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  pulses = 3'h0;
    logic [31:0] level = 32'h0000FFFF;
    logic [31:0] pin_in, pin_analog, dir_input;
    logic [15:0] rdata;
    logic [2:0]  ref_sel;
    logic        rc_clk_sel, tad_tick, conv_busy, conv_done;
    logic [4:0]  ch0_pos, ch0_neg, ch1_pos, ch2_pos, ch3_pos, ch123_neg;
    int          n_fail = 0;
    int          checks = 0;

    pin_model #(.N(32)) i_pin_model (.level(level), .pin(pin_in));
    adc_input_select_clock #(.NPINS(32)) i_adc_input_select_clock (
        .CLK_SYS(clk_sys), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SAMPLE_PULSE(pulses[0]),
        .SEQ_END(pulses[1]), .IRQ_PULSE(pulses[2]), .PIN_IN(pin_in),
        .PIN_OUT(), .REF_SEL(ref_sel), .RC_CLK_SEL(rc_clk_sel),
        .TAD_TICK(tad_tick), .CONV_BUSY(conv_busy), .CONV_DONE(conv_done),
        .CH0_POS(ch0_pos), .CH0_NEG(ch0_neg), .CH1_POS(ch1_pos),
        .CH2_POS(ch2_pos), .CH3_POS(ch3_pos), .CH123_NEG(ch123_neg),
        .PIN_ANALOG(pin_analog), .DIR_INPUT(dir_input));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, e});
    endtask
    task automatic pls(input logic [2:0] m);
        @(posedge clk_sys);
        pulses <= m;
        @(posedge clk_sys);
        pulses <= 3'h0;
        tick(3);
    endtask
    function automatic logic [24:0] mux_now();
        return {ch0_pos, ch0_neg, ch1_pos, ch3_pos, ch123_neg};
    endfunction
    // Starts one conversion, counts its ticks and checks their spacing.
    task automatic conv(input int exp_ticks, input int per);
        int n;
        int last;
        n = 0;
        last = -1;
        wrr(`REG_SEQ_CTRL, 16'h0001);
        for (int i = 0; i < 4000; i++) begin
            tick(1);
            if (conv_done === 1'b1) break;
            if (tad_tick === 1'b1 && conv_busy === 1'b1) begin
                if (last >= 0) chk(i - last, per);
                last = i;
                n++;
            end
        end
        if (conv_done !== 1'b1) begin
            n_fail++;
            conclude();
        end
        chk(n, exp_ticks);
    endtask

    task automatic t_reset;
        chk(dir_input, 32'hFFFFFFFF);
        chk(pin_analog, 32'hFFFFFFFF);
        rdc(`REG_PIN_DIGITAL_CFG_LOW, 16'h0000);
        rdc(`REG_PIN_DIGITAL_CFG_HIGH, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_ref;
        for (int v = 0; v < 8; v++) begin
            wrr(`REG_CON2, 16'(v) << 13);
            tick(3);
            chk(ref_sel, v);
        end
        wrr(`REG_CON2, 16'h0000);
        $display("reference test done");
    endtask
    task automatic t_clk;
        int n;
        n = 0;
        wrr(`REG_CON1, 16'h0000);
        wrr(`REG_CON3, 16'h0001);
        tick(620);
        conv(12, 2);
        wrr(`REG_CON1, 16'h0400);
        wrr(`REG_CON3, 16'h0002);
        tick(620);
        conv(14, 3);
        wrr(`REG_CON3, 16'h8002);
        tick(3);
        chk(rc_clk_sel, 1);
        repeat (100) begin
            tick(1);
            if (tad_tick !== 1'b0) n++;
        end
        chk(n, 0);
        wrr(`REG_CON3, 16'h0001);
        wrr(`REG_CON1, 16'h0000);
        $display("clock test done");
    endtask
    task automatic t_pins;
        wrr(`REG_PIN_DIGITAL_CFG_LOW, 16'h00F0);
        wrr(`REG_CH0_SEL, 16'h0085);
        tick(4);
        chk(pin_analog[15:0], 16'hFF0F);
        rdc(`REG_PORT, 16'h00F0);
        chk(ch0_pos, `INPUT_GROUND);
        chk(ch0_neg, 1);
        wrr(`REG_CH0_SEL, 16'h0003);
        tick(3);
        chk({ch0_pos, ch0_neg}, {5'd3, `NEG_SEL_VREF});
        wrr(`REG_DIRECTION, 16'h0000);
        tick(3);
        chk(dir_input[15:0], 16'h0000);
        wrr(`REG_PIN_DIGITAL_CFG_LOW, 16'h0000);
        $display("pin test done");
    endtask
    task automatic t_alt;
        wrr(`REG_CH0_SEL, 16'h8902);
        wrr(`REG_CH123_SEL, 16'h0704);
        wrr(`REG_CON2, 16'h0001);
        tick(3);
        chk(mux_now(), {5'd2, `NEG_SEL_VREF, 5'd0, 5'd2, 5'd6});
        pls(3'b001);
        chk(mux_now(), {5'd9, 5'd1, 5'd3, 5'd5, 5'd9});
        wrr(`REG_CON2, 16'h0000);
        tick(3);
        chk(mux_now(), {5'd2, `NEG_SEL_VREF, 5'd0, 5'd2, 5'd6});
        $display("alternation test done");
    endtask
    task automatic t_scan;
        wrr(`REG_SCAN_LOW, 16'h0052);
        wrr(`REG_CH0_SEL, 16'h0083);
        wrr(`REG_CON2, 16'h0400);
        pls(3'b100);
        chk({ch0_pos, ch0_neg}, {5'd1, 5'd1});
        pls(3'b010);
        chk(ch0_pos, 4);
        pls(3'b100);
        chk(ch0_pos, 1);
        pls(3'b010);
        pls(3'b010);
        chk(ch0_pos, 6);
        $display("scan test done");
    endtask
    // Sequential alternation waits for both channels; scan alternates with B.
    task automatic t_seq;
        wrr(`REG_CH0_SEL, 16'h0902);
        wrr(`REG_CON2, 16'h0101);
        pls(3'b001);
        chk({ch0_pos, ch2_pos}, {5'd2, 5'd1});
        pls(3'b001);
        chk({ch0_pos, ch2_pos}, {5'd9, 5'd4});
        wrr(`REG_CON1, 16'h0008);
        pls(3'b001);
        chk(ch0_pos, 2);
        wrr(`REG_CON2, 16'h0401);
        pls(3'b100);
        chk(ch0_pos, 1);
        pls(3'b001);
        chk(ch0_pos, 9);
        pls(3'b010);
        pls(3'b001);
        chk(ch0_pos, 4);
        wrr(`REG_CON1, 16'h0000);
        $display("sequence test done");
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        tick(1);
        t_reset();
        t_ref();
        t_clk();
        t_pins();
        t_alt();
        t_scan();
        t_seq();
        conclude();
    end
endmodule
